// >>> rtl/gpc_gpio_port.sv
// sixteen-pin gpio configuration, de-bounce, edge and drive-check logic
// Notes on behaviour
// - pads high impedance during and after reset
// - input invert bit flips input path
// - separate high and low drive enables
// - output invert bit flips driven data
// - two analog switch enables, default open
// - pull-up and pull-down enables, default off
// - per-pin rising and falling edge latches
// - two line enables route pin events
// - rise flag set; cleared by enable zero
// - fall flag set; cleared by enable zero
// - disabled input buffer reads as zero, or as one with input invert set
// - output change checked three cycles later
// - mismatch interrupts only with line enable
// - clearing check enable clears error flag
// - filtered input feeds edge latches; drive check uses raw; raw readable
// - filter time off, 4, 16, 64 slow periods
// - bits 1,0 read status, write filter
// - bits 5,4 read flags, write enables
// - sixteen output config registers, reset zero
// - sixteen function select registers, reset zero
`timescale 1ns/10ps
module gpc_gpio_port
    import gpc_pkg::*;
#(
    parameter int NPINS = GPC_PINS
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic slowClkTick,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NPINS-1:0] padIn,
    input wire logic [NPINS-1:0] coreOut,
    output logic [NPINS-1:0] padOut,
    output gpc_pad_ctl_t [NPINS-1:0] padCtl,
    output logic [NPINS-1:0] filteredLevel,
    output logic [NPINS*8-1:0] portFunctionSelect,
    output logic pinIrqLine0,
    output logic pinIrqLine1
);
    logic [7:0] outCfg_r [NPINS];
    logic [7:0] funcSel_r [NPINS];
    logic [NPINS-1:0] line1En_r, line0En_r, riseEn_r, fallEn_r;
    logic [NPINS-1:0] inbufEn_r, checkEn_r;
    logic [1:0] filtTime_r [NPINS];
    logic [NPINS-1:0] riseFlag_r, fallFlag_r, checkFlag_r;
    logic [NPINS-1:0] syncA_r, syncB_r, filt_r, filtPrev_r;
    logic [6:0] filtCnt_r [NPINS];
    logic [NPINS-1:0] outPrev_r;
    logic [CHECK_DELAY_CYCLES-1:0] chkPipe_r [NPINS];
    logic [NPINS-1:0] rawLevel, drvData;
    logic access, wrEn;
    logic [15:0] regIdx;
    logic [3:0] idx;
    logic [1:0] grp;
    logic hit;

    function automatic logic [6:0] filtLimit(input logic [1:0] sel);
        case (sel)
            GPC_FILT_4: filtLimit = 7'(FILT_SHORT);
            GPC_FILT_16: filtLimit = 7'(FILT_MID);
            GPC_FILT_64: filtLimit = 7'(FILT_LONG);
            default: filtLimit = 7'h00;
        endcase
    endfunction : filtLimit

    // each register owns one word: byte address is four times its index
    assign access = psel && penable;
    assign pready = 1'b1;
    assign regIdx = paddr[17:2];
    assign idx = regIdx[3:0];
    always_comb begin
        grp = 2'h3;
        if (regIdx[15:4] == OUT_CFG_BASE[15:4]) begin
            grp = 2'h0;
        end else if (regIdx[15:4] == IN_CFG_BASE[15:4]) begin
            grp = 2'h1;
        end else if (regIdx[15:4] == FUNC_SEL_BASE[15:4]) begin
            grp = 2'h2;
        end
    end
    assign hit = (grp != 2'h3) && (32'(idx) < NPINS);
    assign pslverr = access && !hit;
    assign wrEn = access && pwrite && hit;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite && hit) begin
            case (grp)
                2'd0: prdata <= {24'h0, outCfg_r[idx]};
                2'd1: prdata <= {24'h0, line1En_r[idx], line0En_r[idx],
                    riseFlag_r[idx], fallFlag_r[idx], inbufEn_r[idx],
                    checkFlag_r[idx], filt_r[idx], rawLevel[idx]};
                default: prdata <= {24'h0, funcSel_r[idx]};
            endcase
        end else if (psel && !penable) begin
            prdata <= 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < NPINS; i++) begin
                outCfg_r[i] <= OUT_CFG_RESET;
                funcSel_r[i] <= FUNC_SEL_RESET;
                filtTime_r[i] <= IN_CFG_RESET[1:0];
            end
            line1En_r <= '0;
            line0En_r <= '0;
            riseEn_r <= '0;
            fallEn_r <= '0;
            inbufEn_r <= '0;
            checkEn_r <= '0;
        end else if (wrEn) begin
            case (grp)
                2'd0: outCfg_r[idx] <= pwdata[7:0];
                2'd1: begin
                    line1En_r[idx] <= pwdata[IC_LINE1_EN];
                    line0En_r[idx] <= pwdata[IC_LINE0_EN];
                    riseEn_r[idx] <= pwdata[IC_RISE];
                    fallEn_r[idx] <= pwdata[IC_FALL];
                    inbufEn_r[idx] <= pwdata[IC_INBUF_EN];
                    checkEn_r[idx] <= pwdata[IC_CHECK];
                    filtTime_r[idx] <= pwdata[IC_FILT_HI:IC_FILT_LO];
                end
                default: funcSel_r[idx] <= pwdata[7:0];
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : gPin
            assign padCtl[g].highSideDriveEn = outCfg_r[g][OC_HIGH_DRV];
            assign padCtl[g].lowSideDriveEn = outCfg_r[g][OC_LOW_DRV];
            assign padCtl[g].analogSwitchAEn = outCfg_r[g][OC_ANALOG_A];
            assign padCtl[g].analogSwitchBEn = outCfg_r[g][OC_ANALOG_B];
            assign padCtl[g].pullupResistorEn = outCfg_r[g][OC_PULLUP];
            assign padCtl[g].pulldownResistorEn =
                outCfg_r[g][OC_PULLDOWN];
            assign drvData[g] = coreOut[g] ^ outCfg_r[g][OC_OUTPUT_INVERT];
            assign portFunctionSelect[g*8 +: 8] = funcSel_r[g];
            // invert before sync so every later stage sees one polarity
            assign rawLevel[g] = syncB_r[g];
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (rst) begin
            padOut <= '0;
        end else begin
            padOut <= drvData;
        end
    end

    // gated buffer forces zero, invert applied ahead of sync
    always_ff @(posedge core_clk) begin
        if (rst) begin
            syncA_r <= '0;
            syncB_r <= '0;
        end else begin
            for (int i = 0; i < NPINS; i++) begin
                syncA_r[i] <= (padIn[i] & inbufEn_r[i])
                    ^ outCfg_r[i][OC_INPUT_INVERT];
            end
            syncB_r <= syncA_r;
        end
    end

    // counts slow ticks of stable level; off passes straight through
    always_ff @(posedge core_clk) begin
        if (rst) begin
            filt_r <= '0;
            for (int i = 0; i < NPINS; i++) begin
                filtCnt_r[i] <= 7'h00;
            end
        end else begin
            for (int i = 0; i < NPINS; i++) begin
                if (filtTime_r[i] == GPC_FILT_OFF
                        || syncB_r[i] == filt_r[i]) begin
                    filt_r[i] <= (filtTime_r[i] == GPC_FILT_OFF)
                        ? syncB_r[i] : filt_r[i];
                    filtCnt_r[i] <= 7'h00;
                end else if (slowClkTick) begin
                    if (filtCnt_r[i] + 7'h01 >= filtLimit(filtTime_r[i])) begin
                        filt_r[i] <= syncB_r[i];
                        filtCnt_r[i] <= 7'h00;
                    end else begin
                        filtCnt_r[i] <= filtCnt_r[i] + 7'h01;
                    end
                end
            end
        end
    end
    assign filteredLevel = filt_r;

    // a set in the same cycle as the clearing write holds one cycle, then the zero enable clears it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            filtPrev_r <= '0;
            riseFlag_r <= '0;
            fallFlag_r <= '0;
        end else begin
            filtPrev_r <= filt_r;
            for (int i = 0; i < NPINS; i++) begin
                if (filt_r[i] && !filtPrev_r[i] && riseEn_r[i]
                        && (line0En_r[i] || line1En_r[i])) begin
                    riseFlag_r[i] <= 1'b1;
                end else if (!riseEn_r[i]) begin
                    riseFlag_r[i] <= 1'b0;
                end
                if (!filt_r[i] && filtPrev_r[i] && fallEn_r[i]
                        && (line0En_r[i] || line1En_r[i])) begin
                    fallFlag_r[i] <= 1'b1;
                end else if (!fallEn_r[i]) begin
                    fallFlag_r[i] <= 1'b0;
                end
            end
        end
    end

    // compare needs the raw buffer, not the slow filtered copy
    always_ff @(posedge core_clk) begin
        if (rst) begin
            outPrev_r <= '0;
            checkFlag_r <= '0;
            for (int i = 0; i < NPINS; i++) begin
                chkPipe_r[i] <= '0;
            end
        end else begin
            outPrev_r <= padOut;
            for (int i = 0; i < NPINS; i++) begin
                chkPipe_r[i] <= {chkPipe_r[i][CHECK_DELAY_CYCLES-2:0],
                    (padOut[i] != outPrev_r[i]) && checkEn_r[i]};
                if (!checkEn_r[i]) begin
                    checkFlag_r[i] <= 1'b0;
                end else if (chkPipe_r[i][CHECK_DELAY_CYCLES-1]
                        && (syncB_r[i] != (padOut[i]
                        ^ outCfg_r[i][OC_INPUT_INVERT]))) begin
                    checkFlag_r[i] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pinIrqLine0 <= 1'b0;
            pinIrqLine1 <= 1'b0;
        end else begin
            pinIrqLine0 <= |(line0En_r
                & (riseFlag_r | fallFlag_r | checkFlag_r));
            pinIrqLine1 <= |(line1En_r
                & (riseFlag_r | fallFlag_r | checkFlag_r));
        end
    end
endmodule : gpc_gpio_port

// >>> rtl/gpc_pkg.sv
// package for the gpio pin configuration and interrupt block
package gpc_pkg;
    localparam int GPC_PINS = 16;
    localparam logic [15:0] OUT_CFG_BASE = 16'hA100;
    localparam logic [15:0] IN_CFG_BASE = 16'hA110;
    localparam logic [15:0] FUNC_SEL_BASE = 16'hA120;
    localparam logic [7:0] OUT_CFG_RESET = 8'h00;
    localparam logic [7:0] IN_CFG_RESET = 8'h00;
    localparam logic [7:0] FUNC_SEL_RESET = 8'h00;
    // output config fields
    localparam int OC_INPUT_INVERT = 7;
    localparam int OC_HIGH_DRV = 6;
    localparam int OC_LOW_DRV = 5;
    localparam int OC_OUTPUT_INVERT = 4;
    localparam int OC_ANALOG_B = 3;
    localparam int OC_ANALOG_A = 2;
    localparam int OC_PULLUP = 1;
    localparam int OC_PULLDOWN = 0;
    // input config fields
    localparam int IC_LINE1_EN = 7;
    localparam int IC_LINE0_EN = 6;
    localparam int IC_RISE = 5;
    localparam int IC_FALL = 4;
    localparam int IC_INBUF_EN = 3;
    localparam int IC_CHECK = 2;
    localparam int IC_FILT_HI = 1;
    localparam int IC_FILT_LO = 0;
    // timing
    localparam int CHECK_DELAY_CYCLES = 3;
    localparam int FILT_SHORT = 4;
    localparam int FILT_MID = 16;
    localparam int FILT_LONG = 64;

    typedef enum logic [1:0] {
        GPC_FILT_OFF = 2'b00,
        GPC_FILT_4 = 2'b01,
        GPC_FILT_16 = 2'b10,
        GPC_FILT_64 = 2'b11
    } gpc_filt_t;

    typedef struct packed {
        logic highSideDriveEn;
        logic lowSideDriveEn;
        logic analogSwitchAEn;
        logic analogSwitchBEn;
        logic pullupResistorEn;
        logic pulldownResistorEn;
    } gpc_pad_ctl_t;
endpackage : gpc_pkg

// >>> tb/gpc_gpio_port_asserts.sv
// assertions on the gpio port's register bus and pad controls
`timescale 1ns/10ps
module gpc_gpio_port_asserts
    import gpc_pkg::*;
#(
    parameter int NPINS = GPC_PINS
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire gpc_pad_ctl_t [NPINS-1:0] padCtl,
    input wire logic [NPINS*8-1:0] portFunctionSelect,
    input wire logic pinIrqLine0,
    input wire logic pinIrqLine1
);
    logic wrAcc;
    assign wrAcc = psel && penable && pwrite;
    default clocking cb @(posedge core_clk);
    endclocking
    pads_reset_off_a: assert property (rst |=> padCtl == '0)
        else $error("pad controls on after reset");
    outs_reset_zero_a: assert property (rst |=> !pinIrqLine0 &&
        !pinIrqLine1 && portFunctionSelect == '0)
        else $error("outputs set after reset");
    drive_en_write_a: assert property (disable iff (rst)
        wrAcc && paddr == {OUT_CFG_BASE, 2'h0} |=>
        padCtl[0].highSideDriveEn == $past(pwdata[OC_HIGH_DRV]) &&
        padCtl[0].lowSideDriveEn == $past(pwdata[OC_LOW_DRV]))
        else $error("drive enables wrong");
    analog_sw_write_a: assert property (disable iff (rst)
        wrAcc && paddr == {OUT_CFG_BASE + 16'h1, 2'h0} |=>
        padCtl[1].analogSwitchAEn == $past(pwdata[OC_ANALOG_A]) &&
        padCtl[1].analogSwitchBEn == $past(pwdata[OC_ANALOG_B]))
        else $error("analog switches wrong");
    pull_en_write_a: assert property (disable iff (rst)
        wrAcc && paddr == {OUT_CFG_BASE + 16'h2, 2'h0} |=>
        padCtl[2].pullupResistorEn == $past(pwdata[OC_PULLUP]) &&
        padCtl[2].pulldownResistorEn == $past(pwdata[OC_PULLDOWN]))
        else $error("pull enables wrong");
    func_sel_write_a: assert property (disable iff (rst)
        wrAcc && paddr == {FUNC_SEL_BASE + 16'h2, 2'h0} |=>
        portFunctionSelect[23:16] == $past(pwdata[7:0]))
        else $error("function select wrong");
    pad_ctl_hold_a: assert property (disable iff (rst)
        !$stable(padCtl) |-> $past(wrAcc))
        else $error("pad controls moved without a write");
    unmapped_error_a: assert property (
        psel && penable && paddr == 18'h00040 |-> pslverr)
        else $error("no error on unmapped access");
    read_upper_zero_a: assert property (
        psel && penable && !pwrite |-> prdata[31:8] == '0)
        else $error("upper read bits set");
    cover property (wrAcc && paddr == {OUT_CFG_BASE, 2'h0});
    cover property ($rose(pinIrqLine0));
    cover property ($rose(pinIrqLine1));
endmodule : gpc_gpio_port_asserts

// >>> tb/gpc_pad_model.sv
// board-side pads: drivers, pulls, a stronger source, floating nets
`timescale 1ns/10ps
module gpc_pad_model
    import gpc_pkg::*;
#(
    parameter int NPINS = GPC_PINS
) (
    input wire logic core_clk,
    input wire logic [NPINS-1:0] padOut,
    input wire gpc_pad_ctl_t [NPINS-1:0] padCtl,
    input wire logic [NPINS-1:0] fight,
    output logic [NPINS-1:0] padIn
);
    logic flt_r = 1'b0;
    gpc_pad_ctl_t c;
    always @(posedge core_clk) begin
        flt_r <= !flt_r;
    end
    // floating pads toggle so a stale level is never read as valid
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            c = padCtl[i];
            if (fight[i]) padIn[i] = !padOut[i];
            else if (c.highSideDriveEn && padOut[i]) padIn[i] = 1'b1;
            else if (c.lowSideDriveEn && !padOut[i]) padIn[i] = 1'b0;
            else if (c.pullupResistorEn) padIn[i] = 1'b1;
            else if (c.pulldownResistorEn) padIn[i] = 1'b0;
            else padIn[i] = flt_r ^ i[0];
        end
    end
endmodule : gpc_pad_model

// >>> tb/gpio_pin_config_and_interrupt_tb_top.sv
// testbench: random and corner stimulus, pad model, checks, verdict
`timescale 1ns/10ps
module gpio_pin_config_and_interrupt_tb_top;
    import gpc_pkg::*;
    localparam int TICK = 8;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic slowClkTick = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] coreOut = 16'h0;
    logic [15:0] fight = 16'h0;
    logic [31:0] prdata, rd;
    logic [15:0] padIn, padOut, filteredLevel;
    logic pready, pslverr, errSeen, pinIrqLine0, pinIrqLine1, l;
    gpc_pad_ctl_t [15:0] padCtl;
    logic [127:0] portFunctionSelect;
    logic [7:0] v;
    int fails = 0;
    int compares = 0;
    int cyc = 0;
    int n;
    always #5 core_clk = !core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        slowClkTick <= (cyc % TICK == 0);
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end
    gpc_gpio_port #(.NPINS(16)) DUT (.core_clk(core_clk), .rst(rst),
        .slowClkTick(slowClkTick), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .padIn(padIn),
        .coreOut(coreOut), .padOut(padOut), .padCtl(padCtl),
        .filteredLevel(filteredLevel), .pinIrqLine0(pinIrqLine0),
        .portFunctionSelect(portFunctionSelect), .pinIrqLine1(pinIrqLine1));
    gpc_pad_model #(.NPINS(16)) padModel (.core_clk(core_clk),
        .padOut(padOut), .padCtl(padCtl), .fight(fight), .padIn(padIn));
    task automatic conclude();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // byte address of pin i in the bank whose first index is b
    function automatic int ad(input logic [15:0] b, input int i);
        return 4 * (int'(b) + i);
    endfunction : ad
    task automatic apb(input logic w, input int a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= 18'(a);
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic int filtTicks(input int m);
        return m == 1 ? FILT_SHORT : m == 2 ? FILT_MID : m == 3 ? FILT_LONG : 0;
    endfunction : filtTicks
    initial begin
        void'($urandom(15));
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 16; i += 5) begin
            apb(0, ad(OUT_CFG_BASE, i), 0);
            chk(rd, 32'h0);
            apb(0, ad(IN_CFG_BASE, i), 0);
            chk(rd, 32'h0);
            v = 8'($urandom);
            apb(1, ad(FUNC_SEL_BASE, i), {24'h0, v});
            apb(0, ad(FUNC_SEL_BASE, i), 0);
            chk(rd, {24'h0, v});
            chk(32'(portFunctionSelect[8*i+:8]), {24'h0, v});
        end
        apb(0, 32'h40, 0);
        chk({rd[30:0], errSeen}, 32'h1);
        apb(0, ad(16'hA130, 0), 0);
        chk({rd[30:0], errSeen}, 32'h1);
        for (int m = 0; m < 4; m++) begin
            apb(1, ad(OUT_CFG_BASE, 0), {24'h0, m[1], 2'h3, m[0], 4'h0});
            apb(1, ad(IN_CFG_BASE, 0), 32'h08);
            coreOut <= 16'($urandom);
            repeat (6) @(posedge core_clk);
            l = coreOut[0] ^ m[0] ^ m[1];
            chk(32'(padOut[0]), 32'(coreOut[0] ^ m[0]));
            chk(32'(padCtl[0]), 32'h30);
            apb(0, ad(IN_CFG_BASE, 0), 0);
            chk(32'(rd[3:0]), {28'h0, 2'h2, l, l});
        end
        apb(1, ad(OUT_CFG_BASE, 0), 32'h60);
        coreOut <= 16'hFFFF;
        apb(1, ad(IN_CFG_BASE, 0), 32'h00);
        // let the gated zero pass both synchroniser stages first
        repeat (4) @(posedge core_clk);
        apb(0, ad(IN_CFG_BASE, 0), 0);
        chk(rd, 32'h0);
        apb(1, ad(OUT_CFG_BASE, 1), 32'h01);
        apb(1, ad(IN_CFG_BASE, 1), 32'h68);
        apb(1, ad(OUT_CFG_BASE, 1), 32'h02);
        repeat (8) @(posedge core_clk);
        apb(0, ad(IN_CFG_BASE, 1), 0);
        chk(rd, 32'h6B);
        chk(32'({pinIrqLine1, pinIrqLine0}), 32'h1);
        apb(1, ad(IN_CFG_BASE, 1), 32'h48);
        apb(0, ad(IN_CFG_BASE, 1), 0);
        chk(32'({rd[7:0], pinIrqLine0}), 32'({8'h4B, 1'b0}));
        apb(1, ad(IN_CFG_BASE, 1), 32'h98);
        apb(1, ad(OUT_CFG_BASE, 1), 32'h01);
        repeat (8) @(posedge core_clk);
        apb(0, ad(IN_CFG_BASE, 1), 0);
        chk(32'({rd[7:0], pinIrqLine1, pinIrqLine0}),
            32'({8'h98, 2'h2}));
        apb(1, ad(IN_CFG_BASE, 1), 32'h88);
        apb(0, ad(IN_CFG_BASE, 1), 0);
        chk(32'({rd[7:0], pinIrqLine1}), 32'({8'h88, 1'b0}));
        apb(1, ad(OUT_CFG_BASE, 2), 32'h60);
        apb(1, ad(IN_CFG_BASE, 2), 32'h0C);
        coreOut[2] <= !coreOut[2];
        repeat (8) @(posedge core_clk);
        apb(0, ad(IN_CFG_BASE, 2), 0);
        chk(32'(rd[7:2]), 32'h2);
        fight[2] <= 1'b1;
        coreOut[2] <= !coreOut[2];
        repeat (8) @(posedge core_clk);
        apb(0, ad(IN_CFG_BASE, 2), 0);
        chk(32'({rd[7:2], pinIrqLine0}), 32'({6'h3, 1'b0}));
        apb(1, ad(IN_CFG_BASE, 2), 32'h4C);
        repeat (3) @(posedge core_clk);
        chk(32'(pinIrqLine0), 32'h1);
        apb(1, ad(IN_CFG_BASE, 2), 32'h48);
        apb(0, ad(IN_CFG_BASE, 2), 0);
        chk(32'({rd[7:2], pinIrqLine0}), 32'({6'h12, 1'b0}));
        fight[2] <= 1'b0;
        // level flips each pass so every filter setting sees a real edge
        for (int m = 0; m < 4; m++) begin
            apb(1, ad(IN_CFG_BASE, 3), 32'(8'h08 | m));
            apb(1, ad(OUT_CFG_BASE, 3), m[0] ? 32'h01 : 32'h02);
            n = 0;
            while (filteredLevel[3] !== !m[0] && n < 1000) begin
                @(posedge core_clk);
                n++;
            end
            chk(32'(n >= (filtTicks(m) - 1) * TICK), 32'h1);
            chk(32'(n <= (filtTicks(m) + 1) * TICK + 6), 32'h1);
        end
        conclude();
    end
endmodule : gpio_pin_config_and_interrupt_tb_top
bind gpc_gpio_port gpc_gpio_port_asserts #(.NPINS(NPINS)) u_chk (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .padCtl(padCtl), .pinIrqLine0(pinIrqLine0),
    .portFunctionSelect(portFunctionSelect), .pinIrqLine1(pinIrqLine1));
